// file: core/sdcd_pkg.sv
package sdcd_pkg;
  localparam int BANK_W = 3;
  localparam int ROW_W = 16;
  localparam int COL_W = 10;
  localparam int ADDR_W = 16;
  localparam int AUTO_CLOSE_POS = 10;
  localparam int CHOP_SEL_POS = 12;
  localparam int BURST_EIGHT_BEATS = 4;
  localparam int BURST_FOUR_BEATS = 2;
  localparam int CAL_INIT_CYC = 512;
  localparam int CAL_OPER_CYC = 256;
  localparam int CAL_SHORT_CYC = 64;
  localparam int MODE0_LEN_LSB = 0;

  typedef enum logic [3:0] {
    SDCD_NONE = 4'h0,
    SDCD_MRW = 4'h1,
    SDCD_REF = 4'h2,
    SDCD_SR_ENTER = 4'h3,
    SDCD_SR_LEAVE = 4'h4,
    SDCD_PRE = 4'h5,
    SDCD_CLOSE_ALL = 4'h6,
    SDCD_OPEN = 4'h7,
    SDCD_WR = 4'h8,
    SDCD_RD = 4'h9,
    SDCD_LCAL = 4'hA,
    SDCD_SCAL = 4'hB,
    SDCD_PD_ENTER = 4'hC,
    SDCD_PD_LEAVE = 4'hD,
    SDCD_ILL = 4'hE
  } sdcd_cmd_t;

  typedef enum logic [1:0] {
    SDCD_ACTIVE = 2'b00,
    SDCD_PDOWN = 2'b01,
    SDCD_SREF = 2'b10
  } sdcd_state_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
  } sdcd_pins_t;

  typedef struct packed {
    sdcd_cmd_t cmd;
    logic [2:0] bank;
    logic [15:0] addr;
    logic auto_close;
    logic chop4;
  } sdcd_out_t;
endpackage

// file: core/sdcd_decoder.sv
// Function
// - Decode from pin levels at clock rise
// - Decode mode write, refresh, precharge, open
// - Decode write, read, idle, calibration, flag bits
// - Clock-enable edges enter/leave powerdown, self refresh
// - Bank, row, column widths are parameters
// - Hard reset active low, asynchronous
// - Termination input never alters decode
// - Bank field targets bank or mode register
// - Self refresh exit without clock dependency
// - Bursts run to completion uninterrupted
// - Mode zero picks fixed or per-command length
// - Idle command registers nothing new
// - Deselect behaves as idle command
// - No internal refresh during powerdown
// - First long calibration uses initial window
// - Unlisted combinations flagged illegal
// - Opened row stays open until precharge
// - Chop bit used only when per-command enabled
`timescale 1ns/1ns
module sdcd_decoder
  import sdcd_pkg::*;
#(
  parameter int BANKS = 8,
  parameter int BA_W = BANK_W,
  parameter int ROWADDR_W = ROW_W,
  parameter int COLADDR_W = COL_W
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // Command pins from the controller, sampled as external inputs
  input wire logic LINK_CK,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic CKE,
  input wire logic [BA_W-1:0] BA,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic TERM_CTRL,
  // Decoded command
  output logic [3:0] CMD,
  output logic CMD_VALID,
  output logic [BA_W-1:0] CMD_BANK,
  output logic [ADDR_W-1:0] CMD_ADDR,
  output logic AUTO_CLOSE,
  output logic CHOP_FOUR,
  // Status
  output logic [1:0] POWER_STATE,
  output logic BURST_BUSY,
  output logic CAL_BUSY,
  output logic INIT_CAL_DONE,
  output logic ILLEGAL,
  output logic [BANKS-1:0] ROW_OPEN,
  output logic [ADDR_W-1:0] MODE_REG0
);
  // Three-stage synchronisers; stage 0 feeds only stage 1
  localparam int SW = 6 + BA_W + ADDR_W;
  logic [SW-1:0] s0, s1, s2;
  logic [SW-1:0] next_s0;
  logic ck_prev, cke_prev;
  logic next_ck_prev, next_cke_prev;
  sdcd_pins_t pins;
  logic [BA_W-1:0] ba_s;
  logic [ADDR_W-1:0] addr_s;
  logic ck_rise, ck_stable;

  always_comb begin
    next_s0 = {LINK_CK, CS_N, RAS_N, CAS_N, WE_N, CKE, BA, ADDR};
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      s0 <= '0;
      s1 <= '0;
      s2 <= '0;
      ck_prev <= 1'b0;
      // Clock enable taken as high out of reset so the first command decodes
      cke_prev <= 1'b1;
    end else begin
      s0 <= next_s0;
      s1 <= s0;
      s2 <= s1;
      ck_prev <= next_ck_prev;
      cke_prev <= next_cke_prev;
    end
  end

  // Link clock counts as high once stages one and two agree
  assign ck_stable = s1[SW-1] & s2[SW-1];
  assign pins = sdcd_pins_t'(s2[SW-2 -: 5]);
  assign ba_s = s2[BA_W+ADDR_W-1 -: BA_W];
  assign addr_s = s2[ADDR_W-1:0];
  assign ck_rise = ck_stable & ~ck_prev;

  // TERM_CTRL deliberately unused by decode
  sdcd_cmd_t raw;
  logic sr_left, next_sr_left;
  always_comb begin
    next_ck_prev = ck_stable;
    next_cke_prev = ck_rise ? pins.cke : cke_prev;
    raw = SDCD_NONE;
    // An early self refresh exit is still reported as such at the link edge
    if (!cke_prev) begin
      if (pins.cke && (pins.cs_n || (pins.ras_n && pins.cas_n && pins.we_n)))
        raw = (POWER_STATE == SDCD_SREF || sr_left) ? SDCD_SR_LEAVE : SDCD_PD_LEAVE;
    end else if (pins.cs_n) begin
      raw = pins.cke ? SDCD_NONE : SDCD_PD_ENTER;
    end else begin
      case ({pins.ras_n, pins.cas_n, pins.we_n})
        3'b000: raw = pins.cke ? SDCD_MRW : SDCD_ILL;
        3'b001: raw = pins.cke ? SDCD_REF : SDCD_SR_ENTER;
        3'b010: raw = !pins.cke ? SDCD_ILL : addr_s[AUTO_CLOSE_POS] ? SDCD_CLOSE_ALL : SDCD_PRE;
        3'b011: raw = pins.cke ? SDCD_OPEN : SDCD_ILL;
        3'b100: raw = pins.cke ? SDCD_WR : SDCD_ILL;
        3'b101: raw = pins.cke ? SDCD_RD : SDCD_ILL;
        3'b110: raw = !pins.cke ? SDCD_ILL : addr_s[AUTO_CLOSE_POS] ? SDCD_LCAL : SDCD_SCAL;
        3'b111: raw = pins.cke ? SDCD_NONE : SDCD_PD_ENTER;
        default: raw = SDCD_ILL;
      endcase
    end
  end

  // Operational state
  sdcd_state_t pstate, next_pstate;
  logic [2:0] burst_cnt, next_burst_cnt;
  logic [9:0] cal_cnt, next_cal_cnt;
  logic init_done, next_init_done;
  logic [BANKS-1:0] rows, next_rows;
  logic [ADDR_W-1:0] mr0, next_mr0;
  sdcd_out_t o, next_o;
  logic next_valid, valid, next_ill, ill;
  logic chop_pick;
  sdcd_cmd_t eff;
  logic burst_busy, next_burst_busy, cal_busy, next_cal_busy;

  always_comb begin
    eff = ck_rise ? raw : SDCD_NONE;
    // Burst in progress refuses read/write; controller must not try
    if ((eff == SDCD_WR || eff == SDCD_RD) && burst_cnt != 3'h0)
      eff = SDCD_ILL;
    // Opening an already open bank is refused until it is precharged
    if (eff == SDCD_OPEN && rows[ba_s])
      eff = SDCD_ILL;
    next_pstate = pstate;
    next_sr_left = sr_left & ~ck_rise;
    next_burst_cnt = (burst_cnt != 3'h0 && ck_rise) ? burst_cnt - 3'h1 : burst_cnt;
    next_cal_cnt = (cal_cnt != 10'h000) ? cal_cnt - 10'h001 : cal_cnt;
    next_init_done = init_done;
    next_rows = rows;
    next_mr0 = mr0;
    next_o = o;
    next_valid = (eff != SDCD_NONE) && (eff != SDCD_ILL);
    next_ill = eff == SDCD_ILL;
    // Per-command chop only when mode zero enables it; else fixed length
    chop_pick = (mr0[MODE0_LEN_LSB +: 2] == 2'b01) ? ~addr_s[CHOP_SEL_POS]
                                                   : (mr0[MODE0_LEN_LSB +: 2] == 2'b10);
    if (next_valid) begin
      next_o.cmd = eff;
      next_o.bank = ba_s;
      next_o.addr = addr_s;
      next_o.auto_close = addr_s[AUTO_CLOSE_POS];
      next_o.chop4 = (eff == SDCD_WR || eff == SDCD_RD) ? chop_pick : 1'b0;
    end
    case (eff)
      SDCD_MRW: if (ba_s == '0) next_mr0 = addr_s;
      SDCD_OPEN: next_rows[ba_s] = 1'b1;
      SDCD_PRE: next_rows[ba_s] = 1'b0;
      SDCD_CLOSE_ALL: next_rows = '0;
      SDCD_WR, SDCD_RD: begin
        next_burst_cnt = 3'(chop_pick ? BURST_FOUR_BEATS : BURST_EIGHT_BEATS);
        if (addr_s[AUTO_CLOSE_POS]) next_rows[ba_s] = 1'b0;
      end
      SDCD_LCAL: begin
        next_cal_cnt = 10'(init_done ? CAL_OPER_CYC : CAL_INIT_CYC);
        next_init_done = 1'b1;
      end
      SDCD_SCAL: next_cal_cnt = 10'(CAL_SHORT_CYC);
      SDCD_SR_ENTER: next_pstate = SDCD_SREF;
      SDCD_PD_ENTER: next_pstate = SDCD_PDOWN;
      SDCD_SR_LEAVE, SDCD_PD_LEAVE: next_pstate = SDCD_ACTIVE;
      default: next_pstate = next_pstate;
    endcase
    // Self refresh left on settled clock-enable alone, no link edge needed
    if (pstate == SDCD_SREF && pins.cke && s1[SW-6]) begin
      next_pstate = SDCD_ACTIVE;
      next_sr_left = ~ck_rise;
    end
    next_burst_busy = next_burst_cnt != 3'h0;
    next_cal_busy = next_cal_cnt != 10'h000;
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      pstate <= SDCD_ACTIVE;
      burst_cnt <= 3'h0;
      cal_cnt <= 10'h000;
      init_done <= 1'b0;
      rows <= '0;
      mr0 <= '0;
      o <= '0;
      valid <= 1'b0;
      ill <= 1'b0;
      sr_left <= 1'b0;
      burst_busy <= 1'b0;
      cal_busy <= 1'b0;
    end else begin
      pstate <= next_pstate;
      burst_cnt <= next_burst_cnt;
      cal_cnt <= next_cal_cnt;
      init_done <= next_init_done;
      rows <= next_rows;
      mr0 <= next_mr0;
      o <= next_o;
      valid <= next_valid;
      ill <= next_ill;
      sr_left <= next_sr_left;
      burst_busy <= next_burst_busy;
      cal_busy <= next_cal_busy;
    end
  end

  always_comb begin
    CMD = o.cmd;
    CMD_VALID = valid;
    CMD_BANK = o.bank;
    CMD_ADDR = o.addr;
    AUTO_CLOSE = o.auto_close;
    CHOP_FOUR = o.chop4;
    POWER_STATE = pstate;
    BURST_BUSY = burst_busy;
    CAL_BUSY = cal_busy;
    INIT_CAL_DONE = init_done;
    ILLEGAL = ill;
    ROW_OPEN = rows;
    MODE_REG0 = mr0;
  end

  burst_runs_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    (ck_rise && (eff == SDCD_WR || eff == SDCD_RD)) |=> BURST_BUSY)
    else $error("burst not started");
  refused_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    (ck_rise && raw == SDCD_RD && BURST_BUSY) |=> !CMD_VALID)
    else $error("read accepted during burst");
  pd_enter_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    (eff == SDCD_PD_ENTER) |=> POWER_STATE == SDCD_PDOWN)
    else $error("powerdown not entered");
  sr_enter_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    (eff == SDCD_SR_ENTER) |=> POWER_STATE == SDCD_SREF)
    else $error("self refresh not entered");
  cke_low_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    (ck_rise && !cke_prev && !pins.cke) |=> !CMD_VALID && !ILLEGAL)
    else $error("command decoded with clock enable low");
  row_open_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    (eff == SDCD_OPEN) |=> ROW_OPEN[$past(ba_s)])
    else $error("row not marked open");
  init_cal_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    (eff == SDCD_LCAL && !init_done) |=> (cal_cnt == 10'(CAL_INIT_CYC)) && INIT_CAL_DONE)
    else $error("initial calibration window wrong");
  idle_quiet_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    (eff == SDCD_NONE) |=> !CMD_VALID && $stable(MODE_REG0))
    else $error("idle registered a command");
endmodule // sdcd_decoder

// file: bench/sdcd_ctl_model.sv
`timescale 1ns/1ns
module sdcd_ctl_model
  import sdcd_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Command bus
  output logic link_ck,
  output sdcd_pins_t pins,
  output logic [2:0] ba,
  output logic [15:0] addr,
  output logic term_ctrl
);
  initial begin
    link_ck = 1'b0;
    pins = 5'h1F;
    ba = 3'h0;
    addr = 16'h0000;
    term_ctrl = 1'b0;
  end
  // One frame per command; the link clock rests low between frames
  task automatic send(input sdcd_pins_t p, input logic [2:0] b, input logic [15:0] a);
    @(negedge mclk);
    term_ctrl = ~term_ctrl;
    if (p.cs_n) begin
      // Deselected lines carry junk, never the last command
      pins = {1'b1, ~pins.ras_n, ~pins.cas_n, ~pins.we_n, p.cke};
      ba = ~ba;
      addr = ~addr;
    end else begin
      pins = p;
      ba = b;
      addr = a;
    end
    repeat (5) @(negedge mclk);
    link_ck = 1'b1;
    repeat (5) @(negedge mclk);
    link_ck = 1'b0;
  endtask
endmodule // sdcd_ctl_model

// file: bench/test_sdcd_decoder.sv
`timescale 1ns/1ns
module test_sdcd_decoder
  import sdcd_pkg::*;
;
  logic mclk;
  logic resetn;
  logic link_ck;
  sdcd_pins_t pins;
  logic [2:0] ba;
  logic [15:0] addr;
  logic term_ctrl;
  logic [3:0] cmd;
  logic cmd_valid;
  logic [2:0] cmd_bank;
  logic [15:0] cmd_addr;
  logic auto_close;
  logic chop_four;
  logic [1:0] power_state;
  logic burst_busy;
  logic cal_busy;
  logic init_cal_done;
  logic illegal;
  logic [7:0] row_open;
  logic [15:0] mode_reg0;
  logic [3:0] seen;
  int n_mismatch;
  int n_checks;
  int ncal;
  localparam sdcd_pins_t P_MRW = 5'h01;
  localparam sdcd_pins_t P_REF = 5'h03;
  localparam sdcd_pins_t P_PRE = 5'h05;
  localparam sdcd_pins_t P_OPEN = 5'h07;
  localparam sdcd_pins_t P_WR = 5'h09;
  localparam sdcd_pins_t P_RD = 5'h0B;
  localparam sdcd_pins_t P_CAL = 5'h0D;
  localparam sdcd_pins_t P_IDLE = 5'h0F;
  localparam sdcd_pins_t P_DES = 5'h1F;

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  sdcd_ctl_model model (.mclk(mclk), .link_ck(link_ck), .pins(pins), .ba(ba), .addr(addr),
    .term_ctrl(term_ctrl));

  sdcd_decoder DUT (.MCLK(mclk), .RESETN(resetn), .LINK_CK(link_ck), .CS_N(pins.cs_n),
    .RAS_N(pins.ras_n), .CAS_N(pins.cas_n), .WE_N(pins.we_n), .CKE(pins.cke), .BA(ba),
    .ADDR(addr), .TERM_CTRL(term_ctrl), .CMD(cmd), .CMD_VALID(cmd_valid), .CMD_BANK(cmd_bank),
    .CMD_ADDR(cmd_addr), .AUTO_CLOSE(auto_close), .CHOP_FOUR(chop_four), .POWER_STATE(power_state),
    .BURST_BUSY(burst_busy), .CAL_BUSY(cal_busy), .INIT_CAL_DONE(init_cal_done),
    .ILLEGAL(illegal), .ROW_OPEN(row_open), .MODE_REG0(mode_reg0));

  // Pulses are one cycle wide, so they are caught where settled
  always @(negedge mclk) begin
    if (cmd_valid === 1'b1) seen = cmd;
    if (illegal === 1'b1) seen = SDCD_ILL;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic run(input sdcd_pins_t p, input logic [2:0] b, input logic [15:0] a, input logic [3:0] e);
    seen = SDCD_NONE;
    model.send(p, b, a);
    repeat (3) @(negedge mclk);
    chk(16'(seen), 16'(e));
  endtask

  task automatic idle(input int n);
    for (int i = 0; i < n; i++) run(P_IDLE, 3'h0, 16'h0000, SDCD_NONE);
  endtask

  task automatic calwait();
    ncal = 0;
    while (cal_busy === 1'b1 && ncal < 1000) begin
      @(negedge mclk);
      ncal++;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole run is near 1300 cycles; this leaves wide margin
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end

  initial begin
    resetn = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    seen = SDCD_NONE;
    repeat (4) @(negedge mclk);
    chk(16'(power_state), 16'h0000);
    chk(mode_reg0, 16'h0000);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    run(P_MRW, 3'h0, 16'h0001, SDCD_MRW);
    chk(mode_reg0, 16'h0001);
    run(P_MRW, 3'h1, 16'h00AA, SDCD_MRW);
    chk(mode_reg0, 16'h0001);
    run(P_OPEN, 3'h3, 16'h1234, SDCD_OPEN);
    chk({13'h0000, cmd_bank}, 16'h0003);
    chk(cmd_addr, 16'h1234);
    chk(16'(row_open), 16'h0008);
    run(P_OPEN, 3'h3, 16'h0100, SDCD_ILL);
    run(P_RD, 3'h3, 16'h1005, SDCD_RD);
    chk(16'({auto_close, chop_four, burst_busy}), 16'h0001);
    run(P_RD, 3'h3, 16'h0000, SDCD_ILL);
    run(P_IDLE, 3'h2, 16'h0000, SDCD_NONE);
    run(P_DES, 3'h5, 16'h0400, SDCD_NONE);
    idle(1);
    chk(16'(burst_busy), 16'h0000);
    run(P_WR, 3'h3, 16'h0408, SDCD_WR);
    chk(16'({auto_close, chop_four}), 16'h0003);
    idle(3);
    $display("test access done");
    run(P_MRW, 3'h0, 16'h0000, SDCD_MRW);
    run(P_OPEN, 3'h6, 16'h0042, SDCD_OPEN);
    run(P_RD, 3'h6, 16'h0000, SDCD_RD);
    chk(16'(chop_four), 16'h0000);
    idle(3);
    run(P_PRE, 3'h6, 16'h0000, SDCD_PRE);
    chk(16'(row_open[6]), 16'h0000);
    run(P_PRE, 3'h0, 16'h0400, SDCD_CLOSE_ALL);
    chk(16'(row_open), 16'h0000);
    run(P_REF, 3'h0, 16'h0000, SDCD_REF);
    $display("test bank done");
    run(P_CAL, 3'h0, 16'h0400, SDCD_LCAL);
    calwait();
    chk(16'(ncal > 384 && ncal <= CAL_INIT_CYC), 16'h0001);
    chk(16'(init_cal_done), 16'h0001);
    run(P_CAL, 3'h0, 16'h0400, SDCD_LCAL);
    calwait();
    chk(16'(ncal > 192 && ncal <= CAL_OPER_CYC), 16'h0001);
    run(P_CAL, 3'h0, 16'h0000, SDCD_SCAL);
    calwait();
    chk(16'(ncal > 32 && ncal <= CAL_SHORT_CYC), 16'h0001);
    $display("test calibration done");
    run(5'h0E, 3'h0, 16'h0000, SDCD_PD_ENTER);
    chk(16'(power_state), 16'h0001);
    run(5'h02, 3'h0, 16'h0000, SDCD_NONE);
    chk(16'(power_state), 16'h0001);
    run(P_IDLE, 3'h0, 16'h0000, SDCD_PD_LEAVE);
    run(5'h02, 3'h0, 16'h0000, SDCD_SR_ENTER);
    chk(16'(power_state), 16'h0002);
    run(P_DES, 3'h0, 16'h0000, SDCD_SR_LEAVE);
    chk(16'(power_state), 16'h0000);
    run(5'h1E, 3'h0, 16'h0000, SDCD_PD_ENTER);
    run(P_DES, 3'h0, 16'h0000, SDCD_PD_LEAVE);
    $display("test power done");
    run(P_OPEN, 3'h1, 16'h0007, SDCD_OPEN);
    resetn = 1'b0;
    #1;
    chk(16'(row_open), 16'h0000);
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    run(P_OPEN, 3'h1, 16'h0007, SDCD_OPEN);
    chk(16'(row_open), 16'h0002);
    $display("test reset done");
    conclude();
  end
endmodule // test_sdcd_decoder
